// ---- verilog/tdm_fiber_alarm_ais_supervisor.sv ----
// Alarm supervision and AIS substitution for a four-channel fiber multiplexer
//
// Overview of operation
// [R01] Monitor four channels and fiber: LOS, LOF, AIS
// [R02] AIS is an unbroken all-ones stream
// [R03] Received AIS masks the loss-of-frame alarm
// [R04] Fiber failure puts AIS on all channel outputs
// [R05] Channel failure sends AIS toward fiber instead
// [R06] Disabled channel alarms are ignored, no indication
// [R07] Major alarm: power, fiber or channel loss
// [R08] Minor alarm: AIS on fiber or enabled channel
// [R09] Separate indicator per condition, per channel
// [R10] Held call button signalled; received lights call, buzzer
// [R11] Call signalling independent of payload, needs light
// [R12] Test sequence over fiber sets remote loopback
// [R13] Local fiber loopback returns transmit to receive
// [R14] Self-test runs after power-up before operation
// [R15] Per-channel alarm enable, defaults to enabled
// [R16] Alarms held while any cause persists
// [R17] Inserted AIS runs at nominal stream rate
`timescale 1ns/100ps
`include "tdm_fiber_alarm_params.svh"
module tdm_fiber_alarm_ais_supervisor (
  // Clock and reset
  input  wire logic                           mclk,
  input  wire logic                           arst_n,
  // Avalon-MM slave
  input  wire logic [5:0]                     avs_address,
  input  wire logic                           avs_read,
  input  wire logic                           avs_write,
  input  wire logic [31:0]                    avs_writedata,
  output logic      [31:0]                    avs_readdata,
  output logic                                avs_waitrequest,
  output logic                                irq,
  // Tributary receive from channel framers
  input  wire logic [3:0]                     chRxBit,
  input  wire logic [3:0]                     chRxStb,
  input  wire logic [3:0]                     chRxFramed,
  // Tributary streams toward the fiber multiplexer
  output logic      [3:0]                     chUpBit_q,
  output logic      [3:0]                     chUpStb_q,
  // Demultiplexed tributary streams from the fiber
  input  wire logic [3:0]                     dmBit,
  input  wire logic [3:0]                     dmStb,
  // Tributary line outputs
  output logic      [3:0]                     chLineBit_q,
  output logic      [3:0]                     chLineStb_q,
  // Fiber aggregate transmit and receive
  input  wire logic                           fbTxBit,
  input  wire logic                           fbTxStb,
  input  wire logic                           fbRxBit,
  input  wire logic                           fbRxStb,
  input  wire logic                           fbRxFramed,
  output logic                                rxPathBit_q,
  output logic                                rxPathStb_q,
  // Service overhead
  input  wire tdm_fiber_alarm_pkg::svc_oh_t   ohRx,
  output tdm_fiber_alarm_pkg::svc_oh_t        ohTx_q,
  // Panel, jumpers and alarm contacts
  input  wire logic                           callButton,
  input  wire logic [1:0]                     psuFail,
  input  wire logic [3:0]                     channel_alarm_enable_jumper,
  output logic                                callLed_q,
  output logic                                buzzer_q,
  output tdm_fiber_alarm_pkg::led_t           led_q,
  output logic                                majorAlarm_q,
  output logic                                minorAlarm_q
);

  // Stream index 4 is the fiber, 0..3 the channels
  logic [4:0]                     sBit;
  logic [4:0]                     sStb;
  logic [4:0]                     sFramed;
  logic [4:0]                     rawLos;
  logic [4:0]                     rawAis;
  logic [4:0]                     rawLof;
  logic [4:0]                     fail;
  logic [3:0]                     chEn;
  logic                           fibFail;
  logic [14:0]                    alarmVec;
  logic [14:0]                    alarmPrev_q;
  logic [14:0]                    irqSet;
  logic [14:0]                    irqStat_q;
  logic [14:0]                    irqStat_d;
  logic [14:0]                    irqMask_q;
  logic [4:0]                     ctrl_q;
  logic [3:0]                     almEn_q;
  logic                           fiberLoop;
  logic [3:0]                     rlbReq;
  logic [3:0]                     rlbActive_q;
  logic [`LB_HOLD_W-1:0]          lbHold_q;
  logic [7:0]                     lbCode_q;
  logic [`NCO_W:0]                chAcc;
  logic [`NCO_W:0]                fbAcc;
  logic [`NCO_W-1:0]              chNco_q;
  logic [`NCO_W-1:0]              fbNco_q;
  logic                           chTick;
  logic                           fbTick;
  tdm_fiber_alarm_pkg::selftest_t stState_q;
  logic [`ST_W-1:0]               stCnt_q;
  logic [1:0]                     stTickSeen_q;
  logic                           stFail_q;
  logic                           inTest;
  logic                           busReq;
  logic                           busAck;
  logic                           wrStb;
  logic [31:0]                    rdMux;
  logic                           majorNext;
  logic                           minorNext;
  logic                           lightSeen;

  // Address decode used by both the read mux and the write strobes
  function automatic logic hit(input logic [5:0] addr, input logic [5:0] off);
    hit = (addr == off);
  endfunction : hit

  // Nominal rate generators keep substituted streams continuous
  assign chAcc  = {1'b0, chNco_q} + {1'b0, `CH_NCO_INC};  // [R17]
  assign fbAcc  = {1'b0, fbNco_q} + {1'b0, `FB_NCO_INC};  // [R17]
  assign chTick = chAcc[`NCO_W];
  assign fbTick = fbAcc[`NCO_W];

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      chNco_q <= '0;
      fbNco_q <= '0;
    end else begin
      chNco_q <= chAcc[`NCO_W-1:0];
      fbNco_q <= fbAcc[`NCO_W-1:0];
    end
  end

  // Local loopback feeds the fiber monitor from the transmit aggregate
  assign fiberLoop = ctrl_q[`CTRL_FIBER_LOOP];
  assign rlbReq    = ctrl_q[`CTRL_RLB_LSB +: 4];
  assign sBit      = {fiberLoop ? fbTxBit : fbRxBit, chRxBit};  // [R13]
  assign sStb      = {fiberLoop ? fbTxStb : fbRxStb, chRxStb};  // [R13]
  assign sFramed   = {fbRxFramed, chRxFramed};

  // One monitor per stream
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : gMon
      logic [`AIS_RUN_W-1:0] ones_q;
      logic [`LOS_W-1:0]     idle_q;

      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          ones_q <= '0;
          idle_q <= '0;
        end else begin
          if (sStb[g])
            idle_q <= '0;
          else if (idle_q != `LOS_LIMIT)
            idle_q <= idle_q + 1'b1;  // [R01]
          // Any zero restarts the run of ones
          if (sStb[g] && !sBit[g])
            ones_q <= '0;  // [R02]
          else if (sStb[g] && ones_q != `AIS_RUN)
            ones_q <= ones_q + 1'b1;  // [R02]
        end
      end

      assign rawLos[g] = (idle_q == `LOS_LIMIT);  // [R01]
      assign rawAis[g] = (ones_q == `AIS_RUN) && !rawLos[g];  // [R01] [R02]
      // AIS always breaks framing, so its framing alarm is hidden
      assign rawLof[g] = !sFramed[g] && !rawAis[g] && !rawLos[g];  // [R03]
      assign fail[g]   = rawLos[g] | rawAis[g] | !sFramed[g];
    end
  endgenerate

  assign fibFail = fail[4];
  assign chEn    = channel_alarm_enable_jumper & almEn_q;  // [R15]

  // Disabled channels contribute to no indication
  assign alarmVec = {rawAis[4], rawLof[4], rawLos[4],
                     rawAis[3:0] & chEn, rawLof[3:0] & chEn, rawLos[3:0] & chEn};  // [R06]

  assign majorNext = (|psuFail) | rawLos[4] | rawLof[4]
                   | (|(rawLos[3:0] & chEn)) | (|(rawLof[3:0] & chEn));  // [R07]
  assign minorNext = rawAis[4] | (|(rawAis[3:0] & chEn));  // [R08]

  assign inTest = (stState_q != tdm_fiber_alarm_pkg::ST_RUN);

  // Stream substitution
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      chUpBit_q   <= '0;
      chUpStb_q   <= '0;
      chLineBit_q <= '0;
      chLineStb_q <= '0;
      rxPathBit_q <= 1'b0;
      rxPathStb_q <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (rlbActive_q[i] && !fibFail && !inTest) begin
          chUpBit_q[i] <= dmBit[i];
          chUpStb_q[i] <= dmStb[i];
        end else if (fail[i] || inTest) begin
          chUpBit_q[i] <= 1'b1;  // [R05]
          chUpStb_q[i] <= chTick;  // [R05] [R17]
        end else begin
          chUpBit_q[i] <= chRxBit[i];
          chUpStb_q[i] <= chRxStb[i];
        end
        if (fibFail || inTest) begin
          chLineBit_q[i] <= 1'b1;  // [R04]
          chLineStb_q[i] <= chTick;  // [R04] [R17]
        end else begin
          chLineBit_q[i] <= dmBit[i];
          chLineStb_q[i] <= dmStb[i];
        end
      end
      // A dead fiber still yields an all-ones aggregate at line rate
      rxPathBit_q <= fibFail ? 1'b1 : sBit[4];  // [R04]
      rxPathStb_q <= fibFail ? fbTick : sStb[4];  // [R17]
    end
  end

  // Indicators and alarm contacts; lamp test lights every led_q indicator, but not the minor contact
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      led_q        <= '0;
      majorAlarm_q <= 1'b1;
      minorAlarm_q <= 1'b0;
    end else begin
      if (stState_q == tdm_fiber_alarm_pkg::ST_LAMP) begin
        led_q <= '1;
      end else begin
        led_q.fibAis      <= alarmVec[14];  // [R09]
        led_q.fibSyncLoss <= alarmVec[13];  // [R09]
        led_q.fibLos      <= alarmVec[12];  // [R09]
        led_q.chAis       <= alarmVec[11:8];  // [R09]
        led_q.chSyncLoss  <= alarmVec[7:4];  // [R09]
        led_q.chLos       <= alarmVec[3:0];  // [R09]
        led_q.locTest     <= fiberLoop;
        led_q.remTest     <= |(rlbActive_q | rlbReq);
      end
      // Unit is not yet in service during self-test, so major holds
      majorAlarm_q <= majorNext | inTest | stFail_q;  // [R07] [R16]
      minorAlarm_q <= minorNext;  // [R08] [R16]
    end
  end

  // Service overhead: call and loopback sequence
  assign lightSeen = !rawLos[4];

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ohTx_q      <= '0;
      callLed_q   <= 1'b0;
      buzzer_q    <= 1'b0;
      lbCode_q    <= '0;
      lbHold_q    <= '0;
      rlbActive_q <= '0;
    end else begin
      ohTx_q.call     <= callButton;  // [R10]
      ohTx_q.testCode <= {`LB_PREFIX, rlbReq};  // [R12]
      // Independent of framing and payload, needs only received light
      callLed_q <= ohRx.call && lightSeen;  // [R10] [R11]
      buzzer_q  <= ohRx.call && lightSeen;  // [R10] [R11]
      // A code must stay steady for a while before it takes effect
      if (fbRxStb) begin
        lbCode_q <= ohRx.testCode;
        if (ohRx.testCode != lbCode_q)
          lbHold_q <= '0;
        else if (lbHold_q != `LB_HOLD)
          lbHold_q <= lbHold_q + 1'b1;
      end
      if (!lightSeen)
        rlbActive_q <= '0;
      else if (lbHold_q == `LB_HOLD && lbCode_q[7:4] == `LB_PREFIX)
        rlbActive_q <= lbCode_q[3:0];  // [R12]
    end
  end

  // Power-up self-test: lamp test, then check the rate generators
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      stState_q    <= tdm_fiber_alarm_pkg::ST_LAMP;
      stCnt_q      <= '0;
      stTickSeen_q <= '0;
      stFail_q     <= 1'b0;
    end else begin
      case (stState_q)
        tdm_fiber_alarm_pkg::ST_LAMP: begin
          stCnt_q <= stCnt_q + 1'b1;  // [R14]
          if (stCnt_q == `ST_LAMP_CYCLES - 1'b1) begin
            stState_q <= tdm_fiber_alarm_pkg::ST_CHECK;
            stCnt_q   <= '0;
          end
        end
        tdm_fiber_alarm_pkg::ST_CHECK: begin
          stCnt_q <= stCnt_q + 1'b1;  // [R14]
          // Each generator must tick once; their ticks seldom coincide
          stTickSeen_q <= stTickSeen_q | {chTick, fbTick};
          if (stCnt_q == `ST_CHECK_CYCLES - 1'b1) begin
            stState_q <= tdm_fiber_alarm_pkg::ST_RUN;
            stFail_q  <= !(&stTickSeen_q);  // [R14]
          end
        end
        tdm_fiber_alarm_pkg::ST_RUN: begin
          stCnt_q <= '0;
        end
        default: begin
          stState_q <= tdm_fiber_alarm_pkg::ST_LAMP;
        end
      endcase
    end
  end

  // Avalon slave: each access is answered at the second edge
  assign busReq = (avs_read | avs_write) & avs_waitrequest;
  assign busAck = (avs_read | avs_write) & !avs_waitrequest;
  assign wrStb  = avs_write & !avs_waitrequest;

  assign rdMux =
      hit(avs_address, `REG_CTRL)       ? {27'h0000000, ctrl_q} :
      hit(avs_address, `REG_STATUS)     ? {17'h00000, alarmVec} :
      hit(avs_address, `REG_IRQ_STATUS) ? {17'h00000, irqStat_q} :
      hit(avs_address, `REG_IRQ_MASK)   ? {17'h00000, irqMask_q} :
      hit(avs_address, `REG_ALARM_EN)   ? {28'h0000000, almEn_q} :
      hit(avs_address, `REG_SELFTEST)   ? {29'h00000000, stFail_q, !inTest, inTest} :
      32'h00000000;

  // New alarm rises set sticky bits; a set beats a same-cycle clear
  assign irqSet    = alarmVec & ~alarmPrev_q;
  assign irqStat_d = (irqStat_q & ~((wrStb && hit(avs_address, `REG_IRQ_STATUS))
                     ? avs_writedata[14:0] : 15'h0000)) | irqSet;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
    end else begin
      avs_waitrequest <= !busReq;
      if (busReq && avs_read)
        avs_readdata <= rdMux;
      else if (busAck)
        avs_readdata <= '0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q      <= `CTRL_RESET;
      almEn_q     <= `ALARM_EN_RESET;  // [R15]
      irqMask_q   <= `IRQ_MASK_RESET;
      irqStat_q   <= '0;
      alarmPrev_q <= '0;
      irq         <= 1'b0;
    end else begin
      if (wrStb && hit(avs_address, `REG_CTRL))
        ctrl_q <= avs_writedata[4:0];
      if (wrStb && hit(avs_address, `REG_ALARM_EN))
        almEn_q <= avs_writedata[3:0];  // [R06]
      if (wrStb && hit(avs_address, `REG_IRQ_MASK))
        irqMask_q <= avs_writedata[14:0];
      alarmPrev_q <= alarmVec;
      irqStat_q   <= irqStat_d;
      irq         <= |(irqStat_d & irqMask_q);
    end
  end

endmodule : tdm_fiber_alarm_ais_supervisor

// ---- verilog/tdm_fiber_alarm_params.svh ----
// Offsets, reset values and timing counts of the alarm and AIS supervisor
`ifndef TDM_FIBER_ALARM_PARAMS_SVH
`define TDM_FIBER_ALARM_PARAMS_SVH

// Register byte offsets
`define REG_CTRL          6'h00
`define REG_STATUS        6'h04
`define REG_IRQ_STATUS    6'h08
`define REG_IRQ_MASK      6'h0C
`define REG_ALARM_EN      6'h10
`define REG_SELFTEST      6'h14

// Reset values
`define CTRL_RESET        5'h00
`define IRQ_MASK_RESET    15'h0000
`define ALARM_EN_RESET    4'hF

// Control field positions
`define CTRL_FIBER_LOOP   0
`define CTRL_RLB_LSB      1

// Monitor counts in mclk cycles and stream bits
`define AIS_RUN_W         8
`define AIS_RUN           8'hFF
`define LOS_W             10
`define LOS_LIMIT         10'h3FF

// Nominal rate generators: increment = rate / 250 MHz * 65536
`define NCO_W             16
`define CH_NCO_INC        16'h0195
`define FB_NCO_INC        16'h0653

// Loopback test sequence
`define LB_PREFIX         4'hA
`define LB_HOLD_W         6
`define LB_HOLD           6'h20

// Self-test length after reset
`define ST_W              12
`define ST_LAMP_CYCLES    12'h400
`define ST_CHECK_CYCLES   12'h400

`endif

// ---- verilog/tdm_fiber_alarm_pkg.sv ----
// Types shared by the alarm and AIS supervisor
package tdm_fiber_alarm_pkg;

  // Service overhead carried in each direction of the fiber link
  typedef struct packed {
    logic       call;
    logic [7:0] testCode;
  } svc_oh_t;

  // Front-panel indicator set
  typedef struct packed {
    logic       fibAis;
    logic       fibSyncLoss;
    logic       fibLos;
    logic [3:0] chAis;
    logic [3:0] chSyncLoss;
    logic [3:0] chLos;
    logic       locTest;
    logic       remTest;
  } led_t;

  typedef enum logic [1:0] {
    ST_LAMP,
    ST_CHECK,
    ST_RUN
  } selftest_t;

endpackage : tdm_fiber_alarm_pkg

// ---- verification/tdm_fiber_alarm_props.sv ----
// Checker of the alarm supervisor port timing
`timescale 1ns/100ps
module tdm_fiber_alarm_props (
  // Clock and reset
  input wire logic                         mclk,
  input wire logic                         arst_n,
  // Register bus
  input wire logic                         avs_read,
  input wire logic                         avs_write,
  input wire logic [31:0]                  avs_readdata,
  input wire logic                         avs_waitrequest,
  // Streams, panel and alarms
  input wire logic [3:0]                   chRxBit,
  input wire logic [3:0]                   chRxStb,
  input wire logic [3:0]                   chUpBit_q,
  input wire logic [3:0]                   chUpStb_q,
  input wire logic [1:0]                   psuFail,
  input wire logic                         majorAlarm_q,
  input wire logic                         callButton,
  input wire logic                         callLed_q,
  input wire logic                         buzzer_q,
  input wire tdm_fiber_alarm_pkg::svc_oh_t ohRx,
  input wire tdm_fiber_alarm_pkg::svc_oh_t ohTx_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered next cycle");
  a_wait_once: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_rdata_idle: assert property (avs_waitrequest |-> avs_readdata == 32'h0)
    else $error("read data not zero outside answer");
  a_psu_major: assert property (psuFail != 2'h0 |-> ##[1:2] majorAlarm_q)
    else $error("supply failure without major alarm");
  a_call_buzz: assert property (callLed_q == buzzer_q)
    else $error("call lamp and buzzer differ");
  a_call_cause: assert property (callLed_q |-> $past(ohRx.call))
    else $error("call lamp without received call");
  a_call_sent: assert property ($rose(callButton) |-> ##[1:2] ohTx_q.call)
    else $error("held call button not signalled");
  a_up_zero: assert property (chUpStb_q[3] && !chUpBit_q[3] |-> $past(chRxStb[3] && !chRxBit[3]))
    else $error("zero sent upstream without zero input");
endmodule : tdm_fiber_alarm_props

bind tdm_fiber_alarm_ais_supervisor tdm_fiber_alarm_props i_tdm_fiber_alarm_props (
  .mclk(mclk), .arst_n(arst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .chRxBit(chRxBit),
  .chRxStb(chRxStb), .chUpBit_q(chUpBit_q), .chUpStb_q(chUpStb_q), .psuFail(psuFail),
  .majorAlarm_q(majorAlarm_q), .callButton(callButton), .callLed_q(callLed_q),
  .buzzer_q(buzzer_q), .ohRx(ohRx), .ohTx_q(ohTx_q));

// ---- verification/peer_mux_model.sv ----
// Far-end multiplexer seen from the fiber receiver
`timescale 1ns/100ps
module peer_mux_model (
  // Clock and reset
  input wire logic                    mclk,
  input wire logic                    arst_n,
  // Behaviour: 0 data, 1 all-ones, 2 no light
  input wire logic [1:0]              mode,
  input wire logic                    call,
  input wire logic [7:0]              code,
  // Fiber receive toward the block
  output logic                        fbRxBit,
  output logic                        fbRxStb,
  output logic                        fbRxFramed,
  output tdm_fiber_alarm_pkg::svc_oh_t ohRx
);
  logic [1:0] div_q;
  logic       tog_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      div_q   <= 2'h0;
      tog_q   <= 1'b0;
      fbRxStb <= 1'b0;
      fbRxBit <= 1'b0;
    end else begin
      div_q   <= div_q + 2'h1;
      fbRxStb <= (div_q == 2'h3) && (mode != 2'h2);
      if (div_q == 2'h3) tog_q <= !tog_q;
      // Without light the line wanders every cycle instead of holding a value
      fbRxBit <= (mode == 2'h1) ? 1'b1 : (mode == 2'h2) ? !fbRxBit : tog_q;
    end
  end

  assign fbRxFramed = (mode == 2'h0);
  // Overhead keeps flowing whatever the payload does
  assign ohRx = {call, code};
endmodule : peer_mux_model

// ---- verification/test_tdm_fiber_alarm_ais_supervisor.sv ----
// Self-checking bench of the alarm and AIS supervisor
`timescale 1ns/100ps
`include "tdm_fiber_alarm_params.svh"
module test_tdm_fiber_alarm_ais_supervisor;
  logic        mclk, arst_n, avs_read, avs_write, avs_waitrequest, irq;
  logic        fbTxBit, fbTxStb, fbRxBit, fbRxStb, fbRxFramed, rxPathBit_q, rxPathStb_q;
  logic        callButton, callLed_q, buzzer_q, majorAlarm_q, minorAlarm_q, peerCall, ctog;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  chRxBit, chRxStb, chRxFramed, chUpBit_q, chUpStb_q, dmBit, dmStb;
  logic [3:0]  chLineBit_q, chLineStb_q, channel_alarm_enable_jumper, chOn, chOnes;
  logic [2:0]  cdiv;
  logic [1:0]  psuFail, peerMode;
  logic [7:0]  peerCode;
  tdm_fiber_alarm_pkg::svc_oh_t ohRx, ohTx_q;
  tdm_fiber_alarm_pkg::led_t    led_q;
  int          failures, compares;

  tdm_fiber_alarm_ais_supervisor i_tdm_fiber_alarm_ais_supervisor (.mclk, .arst_n,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
    .irq, .chRxBit, .chRxStb, .chRxFramed, .chUpBit_q, .chUpStb_q, .dmBit, .dmStb,
    .chLineBit_q, .chLineStb_q, .fbTxBit, .fbTxStb, .fbRxBit, .fbRxStb, .fbRxFramed,
    .rxPathBit_q, .rxPathStb_q, .ohRx, .ohTx_q, .callButton, .psuFail,
    .channel_alarm_enable_jumper, .callLed_q, .buzzer_q, .led_q, .majorAlarm_q,
    .minorAlarm_q);
  peer_mux_model i_peer_mux_model (.mclk, .arst_n, .mode(peerMode), .call(peerCall),
    .code(peerCode), .fbRxBit, .fbRxStb, .fbRxFramed, .ohRx);

  always #2 mclk = !mclk;

  // Channel framers, demultiplexer and fiber transmitter all tick at the bench's pace
  always @(posedge mclk) begin
    cdiv    <= cdiv + 3'h1;
    chRxStb <= (cdiv == 3'h7) ? chOn : 4'h0;
    dmStb   <= (cdiv == 3'h7) ? 4'hF : 4'h0;
    if (cdiv == 3'h7) ctog <= !ctog;
    chRxBit <= chOnes | {4{ctog}};
    dmBit   <= {4{!ctog}};
    fbTxStb <= (cdiv[1:0] == 2'h1);
    fbTxBit <= cdiv[2];
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    @(posedge mclk);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= wd;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) begin
      failures++;
      give_verdict();
    end
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rdc(input string nm, input logic [5:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(nm, e, x);
  endtask : rdc

  // Every strobe in 1000 cycles carries a one, at the nominal rate
  task automatic ones(input int sel, input int i, input int inc);
    int s, z, k, e;
    logic b, t;
    s = 0;
    z = 0;
    for (k = 0; k < 1000; k++) begin
      @(posedge mclk);
      case (sel)
        0:       {b, t} = {chUpBit_q[i], chUpStb_q[i]};
        1:       {b, t} = {chLineBit_q[i], chLineStb_q[i]};
        default: {b, t} = {rxPathBit_q, rxPathStb_q};
      endcase
      if (t === 1'b1) begin
        s++;
        if (b !== 1'b1) z++;
      end
    end
    e = 1000 * inc / 65536;
    chk("aisZeros", 32'h0, z);
    chk("aisRate", 32'h1, {31'h0, (s == e) || (s == e + 1)});
  endtask : ones

  // Output repeats its source one cycle later: 0 fiber loop, 1 remote loop of channel 0
  task automatic follow(input int sel);
    logic [1:0] pv, cv;
    int k;
    pv = sel ? {dmBit[0], dmStb[0]} : {fbTxBit, fbTxStb};
    for (k = 0; k < 40; k++) begin
      @(posedge mclk);
      cv = sel ? {chUpBit_q[0], chUpStb_q[0]} : {rxPathBit_q, rxPathStb_q};
      chk("loopStream", {30'h0, pv[1] & pv[0], pv[0]}, {30'h0, cv[1] & pv[0], cv[0]});
      pv = sel ? {dmBit[0], dmStb[0]} : {fbTxBit, fbTxStb};
    end
  endtask : follow

  initial begin
    {mclk, arst_n, avs_read, avs_write, callButton, peerCall, ctog} = 7'h00;
    {avs_address, avs_writedata, cdiv, psuFail, peerMode, peerCode, chOnes} = 57'h0;
    {chRxBit, chRxStb, dmBit, dmStb, fbTxBit, fbTxStb} = 18'h0;
    {chRxFramed, channel_alarm_enable_jumper, chOn} = 12'hFFF;
    failures = 0;
    compares = 0;
    repeat (12) @(posedge mclk);
    chk("waitReset", 32'h1, avs_waitrequest);
    chk("majorReset", 32'h1, majorAlarm_q);
    arst_n <= 1'b1;
    repeat (10) @(posedge mclk);
    chk("lampTest", 32'h1FFFF, led_q);
    ones(1, 0, `CH_NCO_INC);
    rdc("alarmEn", `REG_ALARM_EN, 32'hF);
    rdc("irqMask", `REG_IRQ_MASK, 32'h0);
    rdc("ctrl", `REG_CTRL, 32'h0);
    rdc("unmapped", 6'h3C, 32'h0);
    repeat (1100) @(posedge mclk);
    rdc("selftest", `REG_SELFTEST, 32'h2);
    rdc("statusIdle", `REG_STATUS, 32'h0);
    chk("majorIdle", 32'h0, {majorAlarm_q, minorAlarm_q});
    wr(`REG_IRQ_MASK, 32'h7FFF);
    wr(`REG_IRQ_STATUS, 32'h7FFF);
    chRxFramed[0] <= 1'b0;
    repeat (20) @(posedge mclk);
    rdc("statusLof", `REG_STATUS, 32'h10);
    chk("majorLof", 32'h1, {irq, majorAlarm_q} == 2'h3);
    ones(0, 0, `CH_NCO_INC);
    wr(`REG_IRQ_STATUS, 32'h10);
    repeat (3) @(posedge mclk);
    chk("irqClear", 32'h0, irq);
    chRxFramed[0] <= 1'b1;
    wr(`REG_IRQ_MASK, 32'h10);
    repeat (20) @(posedge mclk);
    chk("majorGone", 32'h0, majorAlarm_q);
    {chOnes[1], chRxFramed[1]} <= 2'b10;
    repeat (2200) @(posedge mclk);
    rdc("statusAis", `REG_STATUS, 32'h200);
    chk("minorAis", 32'h2, {majorAlarm_q, minorAlarm_q, irq});
    rdc("irqSticky", `REG_IRQ_STATUS, 32'h220);
    {chOnes[1], chRxFramed[1]} <= 2'b01;
    wr(`REG_IRQ_STATUS, 32'h7FFF);
    wr(`REG_ALARM_EN, 32'hB);
    chOn[2] <= 1'b0;
    repeat (1100) @(posedge mclk);
    rdc("statusOff", `REG_STATUS, 32'h0);
    chk("majorOff", 32'h0, majorAlarm_q);
    wr(`REG_ALARM_EN, 32'hF);
    rdc("statusLos", `REG_STATUS, 32'h4);
    channel_alarm_enable_jumper[2] <= 1'b0;
    rdc("statusJump", `REG_STATUS, 32'h0);
    channel_alarm_enable_jumper[2] <= 1'b1;
    chOn[2] <= 1'b1;
    peerMode <= 2'h1;
    repeat (1200) @(posedge mclk);
    rdc("statusFibAis", `REG_STATUS, 32'h4000);
    chk("minorFib", 32'h1, {majorAlarm_q, minorAlarm_q});
    chk("ledFibAis", 32'h10000, led_q);
    ones(1, 3, `CH_NCO_INC);
    peerCall <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("callLamp", 32'h3, {callLed_q, buzzer_q});
    peerMode <= 2'h2;
    repeat (1100) @(posedge mclk);
    rdc("statusFibLos", `REG_STATUS, 32'h1000);
    chk("majorFib", 32'h2, {majorAlarm_q, callLed_q});
    ones(2, 0, `FB_NCO_INC);
    {peerCall, peerMode} <= 3'h0;
    repeat (50) @(posedge mclk);
    wr(`REG_CTRL, 32'h1);
    repeat (4) @(posedge mclk);
    follow(0);
    chk("ledLoop", 32'h2, led_q);
    wr(`REG_CTRL, 32'h4);
    repeat (3) @(posedge mclk);
    chk("loopCode", 32'hA2, ohTx_q.testCode);
    chk("ledRem", 32'h1, led_q);
    peerCode <= 8'hA1;
    repeat (200) @(posedge mclk);
    follow(1);
    callButton <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("callSent", 32'h1, ohTx_q.call);
    {callButton, psuFail} <= 3'h1;
    repeat (3) @(posedge mclk);
    chk("majorPsu", 32'h1, majorAlarm_q);
    psuFail <= 2'h0;
    repeat (3) @(posedge mclk);
    chk("majorPsuGone", 32'h0, majorAlarm_q);
    give_verdict();
  end
endmodule : test_tdm_fiber_alarm_ais_supervisor
